// ---- isd_map.svh ----
// Constants for the interlock status and diagnostics block
`ifndef ISD_MAP_SVH
`define ISD_MAP_SVH
`define ISD_CLK_HZ 100000000
`define ISD_BLINK_HZ 1
// Half period of the 1 Hz blink in cycles
`define ISD_BLINK_HALF ((`ISD_CLK_HZ / `ISD_BLINK_HZ) / 2)
`define ISD_WARN_MIN 30
// Warning escalation time in cycles
// Worked in 64 bits: thirty minutes of cycles does not fit in 32
`define ISD_WARN_CYC (64'(`ISD_WARN_MIN) * 64'(60) * 64'(`ISD_CLK_HZ))
// Flash code pause length in blink half periods, then the steady-red and no-fault code values
`define ISD_CODE_PAUSE 4
`define ISD_CODE_STEADY 7
`define ISD_CODE_NONE 0
`endif

// ---- isd_pkg.sv ----
// Types for the interlock status and diagnostics block
package isd_pkg;
	typedef struct packed {
		logic guardClosed;
		logic guardLocked;
		logic actuatorIn;
		logic lockPossible;
	} isd_guard_t;
	typedef struct packed {
		logic outOneFault;
		logic outTwoFault;
		logic crossShort;
		logic overTemp;
		logic actuatorFault;
		logic handleFault;
		logic deviceDefect;
	} isd_fault_t;
	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} isd_lamp_t;
	typedef enum logic [1:0] {CODE_PULSE_ON, CODE_PULSE_OFF, CODE_PAUSE} isd_flash_t;
endpackage

// ---- isd_status_diag.sv ----
// Status lamps, safety outputs and diagnostic output of a guard-locking switch
`timescale 1ns/10ps
`include "isd_map.svh"
module isd_status_diag #(
	parameter longint WARN_CYCLES = `ISD_WARN_CYC,
	parameter int BLINK_HALF = `ISD_BLINK_HALF,
	parameter bit POWER_TO_LOCK = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic safetyInputOnePin,
	input wire logic safetyInputTwoPin,
	input wire logic lockCmdPin,
	input wire isd_pkg::isd_guard_t guardPin,
	input wire isd_pkg::isd_fault_t faultPin,
	input wire logic teachIn,
	output isd_pkg::isd_lamp_t lamps,
	output logic safetyOutputOne,
	output logic safetyOutputTwo,
	output logic diagOut,
	output logic lockRequest
);
	// ==========================================================
	// Input synchronisers
	localparam int SW = 4 + 7 + 3;
	logic [SW-1:0] syncA_r;
	logic [SW-1:0] syncB_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= {safetyInputOnePin, safetyInputTwoPin, lockCmdPin, guardPin, faultPin};
			syncB_r <= syncA_r;
		end
	end
	logic inOne, inTwo, lockCmd;
	isd_pkg::isd_guard_t guard;
	isd_pkg::isd_fault_t fault;
	assign {inOne, inTwo, lockCmd, guard, fault} = syncB_r;

	// Command level meaning lock depends on variant
	assign lockRequest = POWER_TO_LOCK ? lockCmd : !lockCmd;

	// ==========================================================
	// Fault classification
	logic warnNow, immNow;
	assign warnNow = fault.outOneFault | fault.outTwoFault | fault.crossShort | fault.overTemp;
	assign immNow = fault.actuatorFault | fault.handleFault | fault.deviceDefect;

	// Code for a fault set; immediate faults take precedence
	function automatic logic [2:0] pickCode(input isd_pkg::isd_fault_t f);
		if (f.deviceDefect) pickCode = 3'(`ISD_CODE_STEADY);
		else if (f.handleFault) pickCode = 3'h6;
		else if (f.actuatorFault) pickCode = 3'h5;
		else if (f.overTemp) pickCode = 3'h4;
		else if (f.crossShort || (f.outOneFault && f.outTwoFault)) pickCode = 3'h3;
		else if (f.outTwoFault) pickCode = 3'h2;
		else if (f.outOneFault) pickCode = 3'h1;
		else pickCode = 3'(`ISD_CODE_NONE);
	endfunction

	// ==========================================================
	// Latched error, warning timer and guard-cycle clear
	logic errLatched_r, errLatched_nxt;
	logic [2:0] errCode_r, errCode_nxt;
	logic sawOpen_r, sawOpen_nxt;
	// Counter sized from the escalation time so the full default fits
	localparam int WW = $clog2(WARN_CYCLES + 1);
	logic [WW-1:0] warnCnt_r, warnCnt_nxt;
	logic warnExpired;
	assign warnExpired = warnCnt_r >= WW'(WARN_CYCLES);
	always_comb begin
		errLatched_nxt = errLatched_r;
		errCode_nxt = errCode_r;
		sawOpen_nxt = sawOpen_r;
		// Warning timer restarts whenever the warning goes away
		warnCnt_nxt = warnNow ? (warnExpired ? warnCnt_r : warnCnt_r + WW'(1)) : '0;
		if (errLatched_r && !guard.guardClosed && !immNow && !warnNow)
			sawOpen_nxt = 1'b1;
		// Clear only when cause gone and guard closed after an opening
		if (errLatched_r && sawOpen_r && guard.guardClosed && !immNow && !warnNow) begin
			errLatched_nxt = 1'b0;
			sawOpen_nxt = 1'b0;
		end
		// New error wins over a clear in the same cycle
		if (immNow || (warnNow && warnExpired)) begin
			errLatched_nxt = 1'b1;
			errCode_nxt = pickCode(fault);
			sawOpen_nxt = 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			errLatched_r <= 1'b0;
			errCode_r <= 3'h0;
			sawOpen_r <= 1'b0;
			warnCnt_r <= '0;
		end else begin
			errLatched_r <= errLatched_nxt;
			errCode_r <= errCode_nxt;
			sawOpen_r <= sawOpen_nxt;
			warnCnt_r <= warnCnt_nxt;
		end
	end

	// ==========================================================
	// Blink base and flash-code sequencer
	logic [31:0] blinkCnt_r, blinkCnt_nxt;
	logic blink_r, blink_nxt;
	logic halfTick;
	isd_pkg::isd_flash_t fl_r, fl_nxt;
	logic [2:0] pulseCnt_r, pulseCnt_nxt;
	logic [2:0] slotCnt_r, slotCnt_nxt;
	logic [2:0] showCode;
	assign halfTick = blinkCnt_r == 32'(BLINK_HALF - 1);
	// Latched error code outranks a live warning code
	assign showCode = errLatched_r ? errCode_r : pickCode(fault);
	always_comb begin
		blinkCnt_nxt = halfTick ? 32'h0 : blinkCnt_r + 32'h1;
		blink_nxt = halfTick ? !blink_r : blink_r;
		fl_nxt = fl_r;
		pulseCnt_nxt = pulseCnt_r;
		slotCnt_nxt = slotCnt_r;
		if (halfTick) begin
			case (fl_r)
				isd_pkg::CODE_PULSE_ON: begin
					fl_nxt = isd_pkg::CODE_PULSE_OFF;
					pulseCnt_nxt = pulseCnt_r + 3'h1;
				end
				isd_pkg::CODE_PULSE_OFF: begin
					// Long pause after the burst lets an observer count it
					if (pulseCnt_r >= showCode) begin
						fl_nxt = isd_pkg::CODE_PAUSE;
						slotCnt_nxt = 3'h0;
					end else begin
						fl_nxt = isd_pkg::CODE_PULSE_ON;
					end
				end
				isd_pkg::CODE_PAUSE: begin
					slotCnt_nxt = slotCnt_r + 3'h1;
					if (slotCnt_r == 3'(`ISD_CODE_PAUSE - 1) && showCode != 3'h0) begin
						fl_nxt = isd_pkg::CODE_PULSE_ON;
						pulseCnt_nxt = 3'h0;
					end
				end
				default: fl_nxt = isd_pkg::CODE_PAUSE;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blinkCnt_r <= 32'h0;
			blink_r <= 1'b0;
			fl_r <= isd_pkg::CODE_PAUSE;
			pulseCnt_r <= 3'h0;
			slotCnt_r <= 3'h0;
		end else begin
			blinkCnt_r <= blinkCnt_nxt;
			blink_r <= blink_nxt;
			fl_r <= fl_nxt;
			pulseCnt_r <= pulseCnt_nxt;
			slotCnt_r <= slotCnt_nxt;
		end
	end

	// ==========================================================
	// Output decode, registered
	isd_pkg::isd_lamp_t lamps_nxt;
	logic outEn_nxt, diag_nxt;
	logic inputsOk, lockedOk;
	assign inputsOk = inOne & inTwo;
	assign lockedOk = guard.guardClosed & guard.guardLocked & guard.actuatorIn;
	always_comb begin
		lamps_nxt.green = 1'b1;
		lamps_nxt.red = 1'b0;
		lamps_nxt.yellow = !guard.guardClosed ? 1'b0 : (guard.guardLocked ? 1'b1 : blink_r);
		// Unlocking disables outputs; relock with actuator in re-enables
		outEn_nxt = inputsOk && lockedOk && !errLatched_r && !teachIn;
		diag_nxt = guard.guardClosed && (guard.lockPossible || guard.guardLocked);
		if (!inputsOk) begin
			lamps_nxt.green = blink_r;
		end
		if (errLatched_r) begin
			lamps_nxt.yellow = 1'b0;
			diag_nxt = 1'b0;
		end else if (warnNow) begin
			diag_nxt = 1'b0;
		end
		if (showCode == 3'(`ISD_CODE_STEADY))
			lamps_nxt.red = 1'b1;
		else if (showCode != 3'h0)
			lamps_nxt.red = fl_r == isd_pkg::CODE_PULSE_ON;
		if (teachIn) begin
			lamps_nxt = '{green: 1'b0, yellow: blink_r, red: 1'b1};
			diag_nxt = 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lamps <= '0;
			safetyOutputOne <= 1'b0;
			safetyOutputTwo <= 1'b0;
			diagOut <= 1'b0;
		end else begin
			lamps <= lamps_nxt;
			safetyOutputOne <= outEn_nxt;
			safetyOutputTwo <= outEn_nxt;
			diagOut <= diag_nxt;
		end
	end

	// ==========================================================
	// Assertions
	sequence immSeen;
		immNow;
	endsequence
	immShutdown_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		immSeen |=> ##1 (!safetyOutputOne && !safetyOutputTwo))
		else $error("outputs on after immediate fault");
	warnKeepsOut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		warnNow && !errLatched_r && !teachIn && !warnExpired |=> !diagOut)
		else $error("diag high during warning");
	warnEscalate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		warnNow && warnExpired |=> errLatched_r)
		else $error("warning not escalated");
	warnReset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!warnNow |=> warnCnt_r == '0)
		else $error("warning timer not reset");
	errHold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		errLatched_r && !sawOpen_r |=> errLatched_r)
		else $error("error cleared without guard cycle");
	outPair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		safetyOutputOne == safetyOutputTwo)
		else $error("safety outputs differ");
	teachLamps_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		teachIn |=> (lamps.red && !lamps.green))
		else $error("teach-in lamps wrong");
	openDiag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!guard.guardClosed && !teachIn |=> !diagOut && !lamps.yellow)
		else $error("open guard shows closed");
	lockMap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lockRequest == (lockCmd ^ !POWER_TO_LOCK))
		else $error("lock command mapping wrong");
endmodule

// ---- isd_ctrl_model.sv ----
// Controller model that drives the lock command of the interlock
`timescale 1ns/10ps
module isd_ctrl_model #(
	parameter bit POWER_TO_LOCK = 1'b0
) (
	ref_clk,
	wantLock,
	lockCmdPin
);
	input wire logic ref_clk;
	input wire logic wantLock;
	output logic lockCmdPin;
	// ==========
	// Command level
	// Starts asking for the lock so the pin is never unknown
	initial lockCmdPin = POWER_TO_LOCK;
	// Level changes off the sampling edge; polarity depends on variant
	always @(negedge ref_clk) begin
		lockCmdPin <= POWER_TO_LOCK ? wantLock : !wantLock;
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the interlock status block
`timescale 1ns/10ps
module testbench;
	localparam int BH = 4;
	localparam int WC = 200;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic inOne = 1'b1;
	logic inTwo = 1'b1;
	logic wantLock = 1'b1;
	logic teachIn = 1'b0;
	logic lockCmdPin;
	isd_pkg::isd_guard_t guard = 4'hF;
	isd_pkg::isd_fault_t fault = 7'h00;
	isd_pkg::isd_lamp_t lamps;
	logic outOne, outTwo, diagOut, lockRequest;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	// ==========
	// Clock, reset and run ceiling
	always #5 ref_clk = ~ref_clk;
	// A hang is cut short well past the expected run length
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	isd_ctrl_model ctrl (.ref_clk(ref_clk), .wantLock(wantLock), .lockCmdPin(lockCmdPin));
	// Short counts keep the warning and blink timing simulable
	isd_status_diag #(.WARN_CYCLES(WC), .BLINK_HALF(BH)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .safetyInputOnePin(inOne), .safetyInputTwoPin(inTwo),
		.lockCmdPin(lockCmdPin), .guardPin(guard), .faultPin(fault), .teachIn(teachIn),
		.lamps(lamps), .safetyOutputOne(outOne), .safetyOutputTwo(outTwo),
		.diagOut(diagOut), .lockRequest(lockRequest));
	// ==========
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] outs();
		return {5'h00, outOne, outTwo, diagOut};
	endfunction
	task automatic reopen();
		guard = 4'h0;
		tick(6);
		guard = 4'hF;
		tick(6);
	endtask
	// Skips to a pause, then counts red rises until the next pause
	task automatic count_burst(output int n);
		int low;
		logic prev;
		low = 0;
		n = 0;
		prev = 1'b0;
		for (int k = 0; k < 400 && low <= 2 * BH; k++) begin
			tick(1);
			low = lamps.red ? 0 : low + 1;
		end
		low = 0;
		for (int k = 0; k < 400 && (low <= 2 * BH || n == 0); k++) begin
			tick(1);
			if (lamps.red === 1'b1 && !prev) n++;
			prev = lamps.red;
			low = lamps.red ? 0 : low + 1;
		end
	endtask
	// ==========
	// Scenarios
	task automatic test_normal();
		tick(6);
		check("outs", outs(), 8'h07);
		check("lamps", 8'(lamps), 8'h06);
		check("lockreq", 8'(lockRequest), 8'h01);
		wantLock = 1'b0;
		tick(4);
		check("unlockreq", 8'(lockRequest), 8'h00);
		wantLock = 1'b1;
		tick(4);
		check("lockreq again", 8'(lockRequest), 8'h01);
		guard = 4'hB;
		tick(6);
		check("unlocked", outs(), 8'h01);
		guard = 4'hF;
		tick(6);
		check("relocked", outs(), 8'h07);
		guard = 4'hA;
		tick(6);
		check("no lock", outs(), 8'h00);
		guard = 4'hF;
		tick(6);
		$display("test normal done");
	endtask
	task automatic test_warning();
		fault = 7'h08;
		tick(6);
		check("warn", outs(), 8'h06);
		fault = 7'h00;
		tick(6);
		check("warn gone", outs(), 8'h07);
		fault = 7'h08;
		tick(WC + 10);
		check("escalate", outs(), 8'h00);
		fault = 7'h00;
		reopen();
		check("cleared", outs(), 8'h07);
		$display("test warning done");
	endtask
	task automatic test_error();
		fault = 7'h04;
		tick(4);
		check("error", outs(), 8'h00);
		fault = 7'h00;
		tick(6);
		check("still latched", outs(), 8'h00);
		reopen();
		check("reset", outs(), 8'h07);
		$display("test error done");
	endtask
	task automatic test_codes();
		int n;
		for (int i = 0; i < 6; i++) begin
			fault = 7'(7'h40 >> i);
			count_burst(n);
			check("pulses", 8'(n), 8'(i + 1));
			fault = 7'h00;
			reopen();
		end
		// Both outputs faulty shows the cross-short code
		fault = 7'h60;
		count_burst(n);
		check("both", 8'(n), 8'h03);
		fault = 7'h00;
		reopen();
		fault = 7'h44;
		count_burst(n);
		check("priority", 8'(n), 8'h05);
		fault = 7'h01;
		tick(6);
		check("defect", {4'h0, outOne, outTwo, diagOut, lamps.red}, 8'h01);
		tick(3 * BH);
		check("steady", 8'(lamps.red), 8'h01);
		fault = 7'h00;
		reopen();
		$display("test codes done");
	endtask
	task automatic test_inputs();
		logic [3:0] seen;
		inTwo = 1'b0;
		guard = 4'hB;
		tick(4);
		seen = 4'h0;
		for (int k = 0; k < 4 * BH; k++) begin
			tick(1);
			seen = seen | {lamps.green, !lamps.green, lamps.yellow, !lamps.yellow};
		end
		check("blink", {3'h0, seen, lamps.red}, 8'h1E);
		teachIn = 1'b1;
		tick(3);
		check("teach", {6'h00, lamps.green, lamps.red}, 8'h01);
		teachIn = 1'b0;
		inTwo = 1'b1;
		guard = 4'hF;
		tick(6);
		$display("test inputs done");
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		tick(3);
		rst_n = 1'b1;
		tick(2);
		test_normal();
		test_warning();
		test_error();
		test_codes();
		test_inputs();
		complete_run();
	end
endmodule
